// ===== design/ffb_map.svh
// offsets, fields, reset values and counts of the block library
`ifndef FFB_MAP_SVH
`define FFB_MAP_SVH

// ==========================================================
// address map, one aligned word each except the sequence and curve tables, which run from their bases
`define FFB_AW            10
`define FFB_OFS_ENABLE    10'h000
`define FFB_OFS_BIN_IN    10'h004
`define FFB_OFS_BIN_OUT   10'h008
`define FFB_OFS_SEL_X0    10'h00C
`define FFB_OFS_SEL_X1    10'h010
`define FFB_OFS_SEL_Y     10'h014
`define FFB_OFS_PCL_T     10'h018
`define FFB_OFS_PDE_T     10'h01C
`define FFB_OFS_PDF_T     10'h020
`define FFB_OFS_PST_T     10'h024
`define FFB_OFS_LAG_X     10'h028
`define FFB_OFS_LAG_SV    10'h02C
`define FFB_OFS_LAG_COEF  10'h030
`define FFB_OFS_LAG_Y     10'h034
`define FFB_OFS_SUB_X0    10'h038
`define FFB_OFS_SUB_X1    10'h03C
`define FFB_OFS_SUB_Y     10'h040
`define FFB_OFS_PHYS_IN   10'h044
`define FFB_OFS_NORM_IN   10'h048
`define FFB_OFS_CRV_Y     10'h04C
`define FFB_OFS_REF       10'h050
`define FFB_OFS_RECIP     10'h054
`define FFB_OFS_PHYS_OUT  10'h058
`define FFB_OFS_STATUS    10'h05C
`define FFB_OFS_SEQ_BASE  10'h060
`define FFB_OFS_CRV_A     10'h100
`define FFB_OFS_CRV_B     10'h180

// ==========================================================
// block indices in enable and sequence
`define FFB_NBLK          12
`define FFB_IDX_NOT       0
`define FFB_IDX_OR        1
`define FFB_IDX_XOR       2
`define FFB_IDX_SEL       3
`define FFB_IDX_LATCH     4
`define FFB_IDX_PCL       5
`define FFB_IDX_PDE       6
`define FFB_IDX_PDF       7
`define FFB_IDX_PST       8
`define FFB_IDX_LAG       9
`define FFB_IDX_CRV       10
`define FFB_IDX_SUB       11

// ==========================================================
// numbers, widths and reset values
`define FFB_NPTS          20
`define FFB_SEQ_W         15
`define FFB_SEQ_MAX       15'h7D00
`define FFB_FRAC          16
`define FFB_ONE           32'h0001_0000
`define FFB_ENABLE_RST    12'h000
`define FFB_TMR_W         32

`endif

// ===== design/ffb_pkg.sv
// types shared by the function block library
package ffb_pkg;

  // ==========================================================
  // timer behaviours
  typedef enum {TM_LIMIT, TM_ON, TM_OFF, TM_STRETCH} ffb_tmode_e;

  // signed fixed point, 16 fraction bits, 1.0 = 100 %
  typedef logic signed [31:0] ffb_fix_t;

  // binary inputs written by software
  typedef struct packed {
    logic       lag_set;
    logic       pst_rst;
    logic       pst_in;
    logic       pdf_in;
    logic       pde_in;
    logic       pcl_in;
    logic       latch_clr;
    logic       latch_set;
    logic       sel_ctl;
    logic [3:0] xor_in;
    logic [3:0] or_in;
    logic       not_in;
  } ffb_bin_s;

  // binary results
  typedef struct packed {
    logic pst_q;
    logic pdf_q;
    logic pde_q;
    logic pcl_q;
    logic latch_qn;
    logic latch_q;
    logic xor_q;
    logic or_q;
    logic not_q;
  } ffb_bout_s;

endpackage

// ===== design/ffb_timer.sv
// one tick-counted pulse timer, behaviour chosen by parameter
`timescale 1ns/1ps
`include "ffb_map.svh"
module ffb_timer import ffb_pkg::*; #(
  parameter ffb_tmode_e MODE = TM_LIMIT,
  parameter int         W    = `FFB_TMR_W
) (
  input  wire logic         clk,   // system clock
  input  wire logic         nrst,  // synchronous reset, active low
  input  wire logic         eval,  // evaluation strobe of this block
  input  wire logic         din,   // binary input
  input  wire logic         rst,   // reset input (stretch mode only)
  input  wire logic [W-1:0] dur,   // duration in ticks
  output logic              q      // binary output
);

  logic         in_d_ff;
  logic [W-1:0] cnt_ff;
  logic         q_ff;
  logic         rise;

  assign rise = din & ~in_d_ff;
  assign q    = q_ff;

  // input history, per evaluation tick
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_d_ff <= 1'b0;
    end else if (eval) begin
      in_d_ff <= din;
    end
  end

  // timer state, advances only on evaluation
  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_ff   <= 1'b0;
      cnt_ff <= '0;
    end else if (eval) begin
      unique case (MODE)
        TM_LIMIT: begin
          if (rise) begin
            q_ff   <= (dur != '0);
            cnt_ff <= dur;
          end else if (q_ff) begin
            if (!din || cnt_ff <= W'(1)) begin
              q_ff <= 1'b0;
            end
            cnt_ff <= (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
          end
        end
        TM_ON: begin
          if (!din) begin
            q_ff   <= 1'b0;
            cnt_ff <= '0;
          end else if (rise) begin
            q_ff   <= (dur == '0);
            cnt_ff <= dur;
          end else if (!q_ff) begin
            if (cnt_ff <= W'(1)) begin
              q_ff <= 1'b1;
            end
            cnt_ff <= (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
          end
        end
        TM_OFF: begin
          // a high input reloads, so a pending clear is dropped
          if (din) begin
            q_ff   <= 1'b1;
            cnt_ff <= dur;
          end else if (q_ff) begin
            if (cnt_ff == '0) begin
              q_ff <= 1'b0;
            end else begin
              cnt_ff <= cnt_ff - W'(1);
            end
          end
        end
        TM_STRETCH: begin
          if (rst) begin
            q_ff   <= 1'b0;
            cnt_ff <= '0;
          end else if (rise) begin
            q_ff   <= 1'b1;
            cnt_ff <= dur;
          end else if (q_ff) begin
            if (!din && cnt_ff <= W'(1)) begin
              q_ff <= 1'b0;
            end
            cnt_ff <= (cnt_ff != '0) ? cnt_ff - W'(1) : cnt_ff;
          end
        end
      endcase
    end
  end

endmodule

// ===== design/ffb_top.sv
// function block library with its sequencer
//
// Operation
// - inverter output is complement of input
// - selector passes first input on 0, second on 1
// - or gate low only when all inputs low
// - limit timer: set on rise, clear on low/expiry
// - on delay: rise after delay, low clears immediately
// - off delay: high follows input, clears after delay
// - input high again cancels pending off clear
// - curve interpolates linearly over 20 breakpoints
// - curve output flat beyond end abscissas
// - stretch timer: set on rise, clear low plus expired
// - stretch reset input forces output low
// - lag output approaches input with time constant
// - lag set input forces output to preset
// - latch: hold, set, clear, clear dominant, complement
// - subtracter difference saturated to numeric range
// - xor gate high for odd count of ones
// - physical input normalised by multiplying with reciprocal value
// - normalised output multiplied back by reference
// - blocks inactive after reset until enabled
// - blocks computed in ascending sequence number order
`timescale 1ns/1ps
`include "ffb_map.svh"
module ffb_top import ffb_pkg::*; #(
  parameter int NPTS = `FFB_NPTS,
  parameter int TW   = `FFB_TMR_W
) (
  input  wire logic                clk,       // 200 MHz system clock
  input  wire logic                nrst,      // synchronous reset, active low
  input  wire logic [`FFB_AW-1:0]  addr,      // register byte address
  input  wire logic [31:0]         wdata,     // write data
  input  wire logic                wr,        // write strobe
  input  wire logic                rd,        // read strobe
  output logic      [31:0]         rdata,     // read data, cycle after rd
  input  wire logic                eval_tick, // cyclic evaluation tick
  output ffb_bout_s                gate_q,    // binary results
  output logic                     busy       // evaluation pass running
);

  localparam int NB = `FFB_NBLK;

  typedef enum {ST_IDLE, ST_RUN} ffb_state_e;

  // ==========================================================
  // registers
  logic [NB-1:0]        enable_ff;
  ffb_bin_s             bin_ff;
  ffb_fix_t             sel_x0_ff, sel_x1_ff, sel_y_ff;
  logic [TW-1:0]        pcl_t_ff, pde_t_ff, pdf_t_ff, pst_t_ff;
  ffb_fix_t             lag_x_ff, lag_sv_ff, lag_coef_ff, lag_y_ff;
  ffb_fix_t             sub_x0_ff, sub_x1_ff, sub_y_ff;
  ffb_fix_t             phys_in_ff, norm_in_ff, crv_y_ff;
  ffb_fix_t             ref_ff, recip_ff, phys_out_ff;
  logic [`FFB_SEQ_W-1:0] seq_ff [NB];
  ffb_fix_t             crv_a_ff [NPTS];
  ffb_fix_t             crv_b_ff [NPTS];
  logic                 not_q_ff, or_q_ff, xor_q_ff, latch_q_ff, latch_qn_ff;
  logic                 pcl_q, pde_q, pdf_q, pst_q;
  logic [31:0]          rdata_ff;
  ffb_state_e           state_ff;
  logic [NB-1:0]        pending_ff;
  logic [3:0]           last_idx_ff;
  logic                 busy_ff;

  // ==========================================================
  // saturate a wide value to the fixed point range
  function automatic ffb_fix_t sat32(input logic signed [65:0] v);
    logic signed [65:0] hi;
    logic signed [65:0] lo;
    hi = 66'sh0_0000_0000_7FFF_FFFF;
    lo = -66'sh0_0000_0000_8000_0000;
    if (v > hi) begin
      sat32 = 32'sh7FFF_FFFF;
    end else if (v < lo) begin
      sat32 = 32'sh8000_0000;
    end else begin
      sat32 = v[31:0];
    end
  endfunction

  // ==========================================================
  // address decode
  logic                 seq_hit, a_hit, b_hit;
  logic [`FFB_AW-1:0]   seq_off, a_off, b_off;
  logic [3:0]           seq_idx;
  logic [4:0]           a_idx, b_idx;

  assign seq_off = addr - `FFB_OFS_SEQ_BASE;
  assign a_off   = addr - `FFB_OFS_CRV_A;
  assign b_off   = addr - `FFB_OFS_CRV_B;
  assign seq_idx = seq_off[5:2];
  assign a_idx   = a_off[6:2];
  assign b_idx   = b_off[6:2];
  assign seq_hit = (addr >= `FFB_OFS_SEQ_BASE) && (addr[1:0] == 2'h0) &&
                   (32'(seq_off) < 32'(4 * NB));
  assign a_hit   = (addr >= `FFB_OFS_CRV_A) && (addr[1:0] == 2'h0) &&
                   (32'(a_off) < 32'(4 * NPTS));
  assign b_hit   = (addr >= `FFB_OFS_CRV_B) && (addr[1:0] == 2'h0) &&
                   (32'(b_off) < 32'(4 * NPTS));

  // software configuration; enables clear at reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      enable_ff   <= `FFB_ENABLE_RST;
      bin_ff      <= '0;
      sel_x0_ff   <= '0;
      sel_x1_ff   <= '0;
      pcl_t_ff    <= '0;
      pde_t_ff    <= '0;
      pdf_t_ff    <= '0;
      pst_t_ff    <= '0;
      lag_x_ff    <= '0;
      lag_sv_ff   <= '0;
      lag_coef_ff <= '0;
      sub_x0_ff   <= '0;
      sub_x1_ff   <= '0;
      phys_in_ff  <= '0;
      ref_ff      <= `FFB_ONE;
      recip_ff    <= `FFB_ONE;
    end else if (wr) begin
      unique case (addr)
        `FFB_OFS_ENABLE:   enable_ff   <= wdata[NB-1:0];
        `FFB_OFS_BIN_IN:   bin_ff      <= wdata[$bits(ffb_bin_s)-1:0];
        `FFB_OFS_SEL_X0:   sel_x0_ff   <= wdata;
        `FFB_OFS_SEL_X1:   sel_x1_ff   <= wdata;
        `FFB_OFS_PCL_T:    pcl_t_ff    <= wdata[TW-1:0];
        `FFB_OFS_PDE_T:    pde_t_ff    <= wdata[TW-1:0];
        `FFB_OFS_PDF_T:    pdf_t_ff    <= wdata[TW-1:0];
        `FFB_OFS_PST_T:    pst_t_ff    <= wdata[TW-1:0];
        `FFB_OFS_LAG_X:    lag_x_ff    <= wdata;
        `FFB_OFS_LAG_SV:   lag_sv_ff   <= wdata;
        `FFB_OFS_LAG_COEF: lag_coef_ff <= wdata;
        `FFB_OFS_SUB_X0:   sub_x0_ff   <= wdata;
        `FFB_OFS_SUB_X1:   sub_x1_ff   <= wdata;
        `FFB_OFS_PHYS_IN:  phys_in_ff  <= wdata;
        `FFB_OFS_REF:      ref_ff      <= wdata;
        `FFB_OFS_RECIP:    recip_ff    <= wdata;
        default: ;
      endcase
    end
  end

  // sequence numbers, clamped on write
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NB; i++) begin
        seq_ff[i] <= '0;
      end
    end else if (wr && seq_hit) begin
      seq_ff[seq_idx] <= (wdata > 32'(`FFB_SEQ_MAX)) ? `FFB_SEQ_MAX
                                                      : wdata[`FFB_SEQ_W-1:0];
    end
  end

  // breakpoint tables; order and padding by software
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < NPTS; i++) begin
        crv_a_ff[i] <= '0;
        crv_b_ff[i] <= '0;
      end
    end else if (wr) begin
      if (a_hit) begin
        crv_a_ff[a_idx] <= wdata;
      end
      if (b_hit) begin
        crv_b_ff[b_idx] <= wdata;
      end
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else if (!rd) begin
      rdata_ff <= '0;
    end else if (seq_hit) begin
      rdata_ff <= 32'(seq_ff[seq_idx]);
    end else if (a_hit) begin
      rdata_ff <= crv_a_ff[a_idx];
    end else if (b_hit) begin
      rdata_ff <= crv_b_ff[b_idx];
    end else begin
      unique case (addr)
        `FFB_OFS_ENABLE:   rdata_ff <= 32'(enable_ff);
        `FFB_OFS_BIN_IN:   rdata_ff <= 32'(bin_ff);
        `FFB_OFS_BIN_OUT:  rdata_ff <= 32'(gate_q);
        `FFB_OFS_SEL_X0:   rdata_ff <= sel_x0_ff;
        `FFB_OFS_SEL_X1:   rdata_ff <= sel_x1_ff;
        `FFB_OFS_SEL_Y:    rdata_ff <= sel_y_ff;
        `FFB_OFS_PCL_T:    rdata_ff <= 32'(pcl_t_ff);
        `FFB_OFS_PDE_T:    rdata_ff <= 32'(pde_t_ff);
        `FFB_OFS_PDF_T:    rdata_ff <= 32'(pdf_t_ff);
        `FFB_OFS_PST_T:    rdata_ff <= 32'(pst_t_ff);
        `FFB_OFS_LAG_X:    rdata_ff <= lag_x_ff;
        `FFB_OFS_LAG_SV:   rdata_ff <= lag_sv_ff;
        `FFB_OFS_LAG_COEF: rdata_ff <= lag_coef_ff;
        `FFB_OFS_LAG_Y:    rdata_ff <= lag_y_ff;
        `FFB_OFS_SUB_X0:   rdata_ff <= sub_x0_ff;
        `FFB_OFS_SUB_X1:   rdata_ff <= sub_x1_ff;
        `FFB_OFS_SUB_Y:    rdata_ff <= sub_y_ff;
        `FFB_OFS_PHYS_IN:  rdata_ff <= phys_in_ff;
        `FFB_OFS_NORM_IN:  rdata_ff <= norm_in_ff;
        `FFB_OFS_CRV_Y:    rdata_ff <= crv_y_ff;
        `FFB_OFS_REF:      rdata_ff <= ref_ff;
        `FFB_OFS_RECIP:    rdata_ff <= recip_ff;
        `FFB_OFS_PHYS_OUT: rdata_ff <= phys_out_ff;
        `FFB_OFS_STATUS:   rdata_ff <= {27'h0, last_idx_ff, busy_ff};
        default:           rdata_ff <= '0;
      endcase
    end
  end

  assign rdata = rdata_ff;

  // ==========================================================
  // sequencer: one block per cycle, lowest number first
  logic                  pick_found;
  logic [3:0]            pick_idx;
  logic [`FFB_SEQ_W-1:0] pick_seq;
  logic [NB-1:0]         strobe;

  // ties go to the lower index
  always_comb begin
    pick_found = 1'b0;
    pick_idx   = '0;
    pick_seq   = '0;
    for (int i = 0; i < NB; i++) begin
      if (pending_ff[i] && (!pick_found || seq_ff[i] < pick_seq)) begin
        pick_found = 1'b1;
        pick_idx   = 4'(i);
        pick_seq   = seq_ff[i];
      end
    end
  end

  assign strobe = (state_ff == ST_RUN && pick_found) ? (NB'(1) << pick_idx) : '0;

  // a tick arriving during a pass is dropped, not queued
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff    <= ST_IDLE;
      pending_ff  <= '0;
      last_idx_ff <= '0;
      busy_ff     <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (eval_tick && enable_ff != '0) begin
            state_ff   <= ST_RUN;
            pending_ff <= enable_ff;
            busy_ff    <= 1'b1;
          end
        end
        ST_RUN: begin
          if (pick_found) begin
            pending_ff[pick_idx] <= 1'b0;
            last_idx_ff          <= pick_idx;
          end
          if ((pending_ff & ~strobe) == '0) begin
            state_ff <= ST_IDLE;
            busy_ff  <= 1'b0;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // gates, selector and latch on their strobes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      not_q_ff   <= 1'b0;
      or_q_ff    <= 1'b0;
      xor_q_ff   <= 1'b0;
      latch_q_ff <= 1'b0;
      latch_qn_ff <= 1'b1;
      sel_y_ff   <= '0;
    end else begin
      if (strobe[`FFB_IDX_NOT]) begin
        not_q_ff <= ~bin_ff.not_in;
      end
      if (strobe[`FFB_IDX_OR]) begin
        or_q_ff <= |bin_ff.or_in;
      end
      if (strobe[`FFB_IDX_XOR]) begin
        xor_q_ff <= ^bin_ff.xor_in;
      end
      if (strobe[`FFB_IDX_SEL]) begin
        sel_y_ff <= bin_ff.sel_ctl ? sel_x1_ff : sel_x0_ff;
      end
      if (strobe[`FFB_IDX_LATCH]) begin
        if (bin_ff.latch_clr) begin
          latch_q_ff <= 1'b0;
          latch_qn_ff <= 1'b1;
        end else if (bin_ff.latch_set) begin
          latch_q_ff <= 1'b1;
          latch_qn_ff <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // pulse timers
  ffb_timer #(.MODE(TM_LIMIT), .W(TW)) u_pcl (
    .clk(clk), .nrst(nrst), .eval(strobe[`FFB_IDX_PCL]),
    .din(bin_ff.pcl_in), .rst(1'b0), .dur(pcl_t_ff), .q(pcl_q)
  );
  ffb_timer #(.MODE(TM_ON), .W(TW)) u_pde (
    .clk(clk), .nrst(nrst), .eval(strobe[`FFB_IDX_PDE]),
    .din(bin_ff.pde_in), .rst(1'b0), .dur(pde_t_ff), .q(pde_q)
  );
  ffb_timer #(.MODE(TM_OFF), .W(TW)) u_pdf (
    .clk(clk), .nrst(nrst), .eval(strobe[`FFB_IDX_PDF]),
    .din(bin_ff.pdf_in), .rst(1'b0), .dur(pdf_t_ff), .q(pdf_q)
  );
  ffb_timer #(.MODE(TM_STRETCH), .W(TW)) u_pst (
    .clk(clk), .nrst(nrst), .eval(strobe[`FFB_IDX_PST]),
    .din(bin_ff.pst_in), .rst(bin_ff.pst_rst), .dur(pst_t_ff), .q(pst_q)
  );

  // both latch outputs registered
  assign gate_q = '{pst_q: pst_q, pdf_q: pdf_q, pde_q: pde_q, pcl_q: pcl_q,
                    latch_qn: latch_qn_ff, latch_q: latch_q_ff,
                    xor_q: xor_q_ff, or_q: or_q_ff, not_q: not_q_ff};
  assign busy   = busy_ff;

  // ==========================================================
  // numeric blocks: lag, subtracter, curve
  logic signed [65:0] lag_step, sub_diff, crv_wide;
  ffb_fix_t           nxt_crv_y;

  // y += (x - y) * coef per tick, coef = tick / time constant
  assign lag_step = 66'(lag_y_ff) +
                    ((66'(lag_x_ff) - 66'(lag_y_ff)) * 66'(lag_coef_ff) >>> `FFB_FRAC);
  assign sub_diff = 66'(sub_x0_ff) - 66'(sub_x1_ff);

  // one-cycle divide: short latency, long path
  always_comb begin
    logic signed [65:0] dx;
    logic signed [65:0] dy;
    logic signed [65:0] den;
    int                 seg;
    dx        = '0;
    dy        = '0;
    den       = 66'sh1;
    seg       = 0;
    crv_wide  = '0;
    if (norm_in_ff <= crv_a_ff[0]) begin
      crv_wide = 66'(crv_b_ff[0]);
    end else if (norm_in_ff >= crv_a_ff[NPTS-1]) begin
      crv_wide = 66'(crv_b_ff[NPTS-1]);
    end else begin
      for (int i = 0; i < NPTS - 1; i++) begin
        if (crv_a_ff[i] <= norm_in_ff) begin
          seg = i;
        end
      end
      dx  = 66'(norm_in_ff) - 66'(crv_a_ff[seg]);
      dy  = 66'(crv_b_ff[seg + 1]) - 66'(crv_b_ff[seg]);
      den = 66'(crv_a_ff[seg + 1]) - 66'(crv_a_ff[seg]);
      if (den == '0) begin
        den = 66'sh1;
      end
      crv_wide = 66'(crv_b_ff[seg]) + (dx * dy) / den;
    end
    nxt_crv_y = sat32(crv_wide);
  end

  // numeric outputs move only on their strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lag_y_ff <= '0;
      sub_y_ff <= '0;
      crv_y_ff <= '0;
    end else begin
      if (strobe[`FFB_IDX_LAG]) begin
        lag_y_ff <= bin_ff.lag_set ? lag_sv_ff : sat32(lag_step);
      end
      if (strobe[`FFB_IDX_SUB]) begin
        sub_y_ff <= sat32(sub_diff);
      end
      if (strobe[`FFB_IDX_CRV]) begin
        crv_y_ff <= nxt_crv_y;
      end
    end
  end

  // ==========================================================
  // scaling between physical and normalised values
  always_ff @(posedge clk) begin
    if (!nrst) begin
      norm_in_ff  <= '0;
      phys_out_ff <= '0;
    end else begin
      norm_in_ff  <= sat32((66'(phys_in_ff) * 66'(recip_ff)) >>> `FFB_FRAC);
      phys_out_ff <= sat32((66'(crv_y_ff) * 66'(ref_ff)) >>> `FFB_FRAC);
    end
  end

endmodule

// ===== sim/ffb_properties.sv
// concurrent checks on the ports of the function block library
`timescale 1ns/1ps
`include "ffb_map.svh"
module ffb_properties import ffb_pkg::*; (
  input wire logic               clk,       // system clock
  input wire logic               nrst,      // reset, low
  input wire logic [`FFB_AW-1:0] addr,      // address
  input wire logic [31:0]        wdata,     // write data
  input wire logic               wr,        // write strobe
  input wire logic               rd,        // read strobe
  input wire logic [31:0]        rdata,     // read data
  input wire logic               eval_tick, // tick
  input wire ffb_bout_s          gate_q,    // results
  input wire logic               busy       // busy
);
  // ==========================================================
  // shadows; pb_ff is what the pass saw
  logic [11:0] en_ff;
  ffb_bin_s    bin_ff;
  ffb_bin_s    pb_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_ff  <= 12'h000;
      bin_ff <= '0;
      pb_ff  <= '0;
    end else begin
      if (wr && addr == `FFB_OFS_ENABLE) en_ff <= wdata[11:0];
      if (wr && addr == `FFB_OFS_BIN_IN) bin_ff <= wdata[17:0];
      pb_ff <= bin_ff;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // assertions
  qn_compl_a: assert property (gate_q.latch_qn == !gate_q.latch_q)
    else $error("qn wrong");
  idle_hold_a: assert property (en_ff == 12'h000 |=> $stable(gate_q))
    else $error("moved while off");
  no_pass_a: assert property (eval_tick && !busy && en_ff == 12'h000 |=> !busy)
    else $error("pass with none on");
  tick_pass_a: assert property (eval_tick && !busy && en_ff != 12'h000 |=> busy)
    else $error("no pass on tick");
  pass_len_a: assert property ($rose(busy) |-> ##[1:12] !busy)
    else $error("pass too long");
  out_pass_a: assert property ($changed(gate_q) |-> $past(busy))
    else $error("change outside pass");
  not_val_a: assert property ($changed(gate_q.not_q) |-> gate_q.not_q == !pb_ff.not_in)
    else $error("not wrong");
  or_val_a: assert property ($changed(gate_q.or_q) |-> gate_q.or_q == |pb_ff.or_in)
    else $error("or wrong");
  xor_val_a: assert property ($changed(gate_q.xor_q) |-> gate_q.xor_q == ^pb_ff.xor_in)
    else $error("xor wrong");
  latch_set_a: assert property ($rose(gate_q.latch_q) |-> pb_ff.latch_set && !pb_ff.latch_clr)
    else $error("bad latch set");
  pst_rst_a: assert property ($rose(gate_q.pst_q) |-> !pb_ff.pst_rst)
    else $error("stretch rose in reset");
  off_clr_a: assert property ($fell(gate_q.pdf_q) |-> !pb_ff.pdf_in)
    else $error("early off clear");
  cover property ($fell(gate_q.pdf_q));
  cover property ($rose(gate_q.latch_q));
  cover property (busy [*2]);
endmodule

bind ffb_top ffb_properties chk_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .eval_tick(eval_tick), .gate_q(gate_q), .busy(busy));

// ===== sim/testbench.sv
// self-checking testbench of the function block library
`timescale 1ns/1ps
`include "ffb_map.svh"
module testbench import ffb_pkg::*; ;
  logic               clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, eval_tick = 1'b0;
  logic [`FFB_AW-1:0] addr = '0;
  logic [31:0]        wdata = '0, rdata;
  logic               busy;
  ffb_bout_s          gate_q;
  int                 n_errors = 0, checks = 0;

  ffb_top dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .eval_tick(eval_tick), .gate_q(gate_q), .busy(busy));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // bus, pass, compare, verdict
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // idle edge keeps strobes single
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk) begin
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
    end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [9:0] a, input logic [31:0] e);
    @(posedge clk) begin
      addr <= a;
      rd   <= 1'b1;
    end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(nm, e, rdata);
  endtask
  task automatic ev;
    @(posedge clk) eval_tick <= 1'b1;
    @(posedge clk) eval_tick <= 1'b0;
    for (int i = 0; i <= 20; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
      if (i == 20) begin
        n_errors++;
        wrap_up();
      end
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk("enable", `FFB_OFS_ENABLE, 32'h0);
    wr_reg(`FFB_OFS_BIN_IN, 32'h0003_FFFF);
    ev;
    chk("busy", 32'h0, busy);
    chk("gate_q", 32'h010, gate_q);
    $display("test reset done");
  endtask
  task automatic t_gates;
    logic lq;
    lq = 1'b0;
    wr_reg(`FFB_OFS_ENABLE, 32'h17);
    for (int i = 0; i < 16; i++) begin
      wr_reg(`FFB_OFS_BIN_IN, {20'h0, i[2], i[1], 1'b0, i[3:0], i[3:0], i[0]});
      ev;
      lq = i[2] ? 1'b0 : (i[1] ? 1'b1 : lq);
      chk("not_q", !i[0], gate_q.not_q);
      chk("or_q", |i[3:0], gate_q.or_q);
      chk("xor_q", ^i[3:0], gate_q.xor_q);
      chk("latch_q", lq, gate_q.latch_q);
      chk("latch_qn", !lq, gate_q.latch_qn);
    end
    $display("test gates done");
  endtask
  // step k: input ins[k], expect exps[k]
  task automatic t_tmr(input string nm, input int eb, input int ib, input int qb,
      input logic [31:0] d, input logic [31:0] base, input int n,
      input logic [7:0] ins, input logic [7:0] exps);
    wr_reg(`FFB_OFS_ENABLE, 32'h1 << eb);
    wr_reg(`FFB_OFS_PCL_T + 10'(4 * (eb - 5)), d);
    for (int k = 0; k < n; k++) begin
      wr_reg(`FFB_OFS_BIN_IN, base | (32'(ins[k]) << ib));
      ev;
      chk(nm, exps[k], gate_q[qb]);
    end
    $display("test %s done", nm);
  endtask
  task automatic t_num;
    wr_reg(`FFB_OFS_ENABLE, 32'hA08);
    wr_reg(`FFB_OFS_SEL_X0, 32'h0001_8000);
    wr_reg(`FFB_OFS_SEL_X1, 32'hFFFF_0000);
    wr_reg(`FFB_OFS_SUB_X0, 32'h7FFF_0000);
    wr_reg(`FFB_OFS_SUB_X1, 32'h8000_0000);
    wr_reg(`FFB_OFS_LAG_SV, 32'h0000_4000);
    wr_reg(`FFB_OFS_LAG_COEF, 32'h0000_8000);
    wr_reg(`FFB_OFS_LAG_X, 32'h0001_0000);
    wr_reg(`FFB_OFS_BIN_IN, 32'h0002_0000);
    ev;
    rd_chk("sel_y", `FFB_OFS_SEL_Y, 32'h0001_8000);
    rd_chk("sub_y", `FFB_OFS_SUB_Y, 32'h7FFF_FFFF);
    rd_chk("lag_y", `FFB_OFS_LAG_Y, 32'h0000_4000);
    wr_reg(`FFB_OFS_BIN_IN, 32'h0000_0200);
    wr_reg(`FFB_OFS_SUB_X0, 32'h0003_0000);
    wr_reg(`FFB_OFS_SUB_X1, 32'h0001_8000);
    ev;
    rd_chk("sel_y", `FFB_OFS_SEL_Y, 32'hFFFF_0000);
    rd_chk("sub_y", `FFB_OFS_SUB_Y, 32'h0001_8000);
    rd_chk("lag_y", `FFB_OFS_LAG_Y, 32'h0000_A000);
    $display("test numeric done");
  endtask
  task automatic t_crv;
    logic [31:0] xs[3] = '{32'hFFFF_0000, 32'h0001_8000, 32'h0020_0000};
    logic [31:0] ys[3] = '{32'h0, 32'h0003_0000, 32'h0026_0000};
    wr_reg(`FFB_OFS_ENABLE, 32'h400);
    for (int i = 0; i < 20; i++) begin
      wr_reg(`FFB_OFS_CRV_A + 10'(4 * i), 32'(i) << 16);
      wr_reg(`FFB_OFS_CRV_B + 10'(4 * i), 32'(i) << 17);
    end
    for (int j = 0; j < 3; j++) begin
      wr_reg(`FFB_OFS_PHYS_IN, xs[j]);
      ev;
      rd_chk("crv_y", `FFB_OFS_CRV_Y, ys[j]);
    end
    wr_reg(`FFB_OFS_REF, 32'h0002_0000);
    wr_reg(`FFB_OFS_RECIP, 32'h0000_8000);
    rd_chk("phys_out", `FFB_OFS_PHYS_OUT, 32'h004C_0000);
    rd_chk("norm_in", `FFB_OFS_NORM_IN, 32'h0010_0000);
    $display("test curve done");
  endtask
  task automatic t_seq;
    wr_reg(`FFB_OFS_ENABLE, 32'h3);
    wr_reg(`FFB_OFS_SEQ_BASE, 32'h5);
    wr_reg(`FFB_OFS_SEQ_BASE + 10'h4, 32'h2);
    ev;
    rd_chk("status", `FFB_OFS_STATUS, 32'h0);
    wr_reg(`FFB_OFS_SEQ_BASE + 10'h4, 32'h7);
    ev;
    rd_chk("status", `FFB_OFS_STATUS, 32'h2);
    wr_reg(`FFB_OFS_SEQ_BASE, 32'h0000_FFFF);
    rd_chk("seq0", `FFB_OFS_SEQ_BASE, 32'h0000_7D00);
    rd_chk("unmapped", 10'h3FC, 32'h0);
    $display("test sequence done");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_gates;
    t_tmr("limit_q", 5, 12, 5, 5, 0, 4, 8'b0110, 8'b0110);
    t_tmr("on_q", 6, 13, 6, 2, 0, 5, 8'b01110, 8'b01000);
    t_tmr("off_q", 7, 14, 7, 2, 0, 7, 8'b0001001, 8'b0111111);
    t_tmr("stretch_q", 8, 15, 8, 8, 0, 3, 8'b010, 8'b110);
    t_tmr("stretch_rst", 8, 16, 8, 8, 32'h8000, 3, 8'b010, 8'b001);
    t_num;
    t_crv;
    t_seq;
    wrap_up();
  end
endmodule
